/* File: rtl/card_file_cmd.sv */
// Card file access command engine: binary and record read/update and record search.
// Assumes an APB3 master on pclk; one transparent file and one record file held on chip.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module card_file_cmd
  import card_file_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  logic [7:0] bin_mem [0:BIN_SIZE-1];
  logic [7:0] rec_mem [0:REC_NUM*REC_LEN-1];
  logic [7:0] buf_r [0:BUF_LEN-1];

  state_t st_r;
  logic [2:0] op_r;
  logic [7:0] p1_r, p2_r, len_r;
  logic cfg_cur_rec_r, cfg_cyc_r, cfg_rd_ok_r, cfg_upd_ok_r;
  logic [4:0] cfg_sfi_bin_r, cfg_sfi_rec_r;
  logic [7:0] srch_le_r, srch_val_r;
  logic [1:0] srch_kind_r;
  logic [4:0] bufptr_r;
  logic [3:0] ptr_r, nptr_r;
  logic [2:0] head_r, nhead_r;
  logic [1:0] err_r;
  logic done_r, to_buf_r, is_rec_r;
  logic [7:0] base_r, cnt_r, resp_cnt_r;
  logic [3:0] srec_r, first_r, erec_r;
  logic [4:0] spos_r, sk_r, start0_r;
  logic sfind_r;
  logic [7:0] match_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;

  // Logical record number to storage slot; record one of a cyclic file sits at head
  function automatic logic [2:0] phys_of(input logic [3:0] lg, input logic cyc,
                                         input logic [2:0] hd);
    logic [3:0] s;
    s = lg - 4'h1 + (cyc ? {1'b0, hd} : 4'h0);
    return s[2:0];
  endfunction : phys_of

  // APB decode
  logic setup, acc, addr_ok, wr, rd_data, idle;
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready_r;
  assign addr_ok = (paddr == ADDR_CMD) || (paddr == ADDR_STATUS) || (paddr == ADDR_FILECFG)
                || (paddr == ADDR_BUFPTR) || (paddr == ADDR_DATA) || (paddr == ADDR_SEARCH);
  assign idle = (st_r == S_IDLE);
  assign wr = acc & pwrite & ~pslverr_r & idle;
  assign rd_data = acc & ~pwrite & idle & (paddr == ADDR_DATA);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ADDR_CMD: rd_mux = {len_r, p2_r, p1_r, 5'h00, op_r};
      ADDR_STATUS: begin
        rd_mux[STS_BUSY] = ~idle;
        rd_mux[STS_DONE] = done_r;
        rd_mux[STS_ERR_LSB +: 2] = err_r;
        rd_mux[STS_CNT_LSB +: 8] = resp_cnt_r;
        rd_mux[STS_PTR_LSB +: 4] = ptr_r;
        rd_mux[STS_HEAD_LSB +: 3] = head_r;
      end
      ADDR_FILECFG: rd_mux = {18'h00000, cfg_sfi_rec_r, cfg_sfi_bin_r, cfg_upd_ok_r,
                              cfg_rd_ok_r, cfg_cyc_r, cfg_cur_rec_r};
      ADDR_BUFPTR: rd_mux = {27'h0000000, bufptr_r};
      ADDR_DATA: rd_mux = {24'h000000, buf_r[bufptr_r]};
      ADDR_SEARCH: rd_mux = {8'h00, srch_val_r, 6'h00, srch_kind_r, srch_le_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait-free access phase; data and error are fixed in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup & ~pready_r;
      if (setup) begin
        pslverr_r <= ~addr_ok;
        prdata_r <= addr_ok ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // Software configuration; changes are refused while a command runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cfg_sfi_rec_r, cfg_sfi_bin_r, cfg_upd_ok_r, cfg_rd_ok_r, cfg_cyc_r,
       cfg_cur_rec_r} <= CFG_RESET;
      srch_le_r <= 8'h00;
      srch_kind_r <= SK_SIMPLE;
      srch_val_r <= 8'h00;
      bufptr_r <= 5'h00;
    end else begin
      if (wr && paddr == ADDR_FILECFG) begin
        cfg_cur_rec_r <= pwdata[CFG_CUR_REC];
        cfg_cyc_r <= pwdata[CFG_CYCLIC];
        cfg_rd_ok_r <= pwdata[CFG_RD_OK];
        cfg_upd_ok_r <= pwdata[CFG_UPD_OK];
        cfg_sfi_bin_r <= pwdata[CFG_SFIB_LSB +: 5];
        cfg_sfi_rec_r <= pwdata[CFG_SFIR_LSB +: 5];
      end
      if (wr && paddr == ADDR_SEARCH) begin
        srch_le_r <= pwdata[SRCH_LE_LSB +: 8];
        srch_kind_r <= pwdata[SRCH_KIND_LSB +: 2];
        srch_val_r <= pwdata[SRCH_VAL_LSB +: 8];
      end
      if (wr && paddr == ADDR_BUFPTR) begin
        bufptr_r <= pwdata[4:0];
      end else if ((wr && paddr == ADDR_DATA) || rd_data) begin
        bufptr_r <= bufptr_r + 5'h01;
      end
    end
  end

  // Command check, done in one cycle before anything is touched
  logic [1:0] c_err;
  logic [15:0] c_off;
  logic [3:0] c_tgt, c_nptr;
  logic [2:0] c_nhead, c_mode;
  logic c_to_buf, c_rec, c_acc_ok;
  always_comb begin
    c_err = ERR_NONE;
    c_off = {1'b0, p1_r[6:0], p2_r};
    c_tgt = ptr_r;
    c_nptr = ptr_r;
    c_nhead = head_r;
    c_mode = p2_r[2:0];
    c_to_buf = (op_r != OP_UPD_BIN) && (op_r != OP_UPD_REC);
    c_rec = (op_r == OP_RD_REC) || (op_r == OP_UPD_REC) || (op_r == OP_SEARCH);
    c_acc_ok = c_to_buf ? cfg_rd_ok_r : cfg_upd_ok_r;
    if (!c_rec) begin
      if (!p1_r[7]) begin
        if (cfg_cur_rec_r) c_err = ERR_PARAM;
      end else if (p1_r[7:5] == P1_SFI_TAG) begin
        c_off = {8'h00, p2_r};
        if (p1_r[4:0] != cfg_sfi_bin_r) c_err = ERR_PARAM;
      end else begin
        c_err = ERR_PARAM;
      end
      if (op_r != OP_RD_BIN && op_r != OP_UPD_BIN) c_err = ERR_PARAM;
      if (c_err == ERR_NONE && !c_acc_ok) c_err = ERR_ACCESS;
      else if (c_err == ERR_NONE && (len_r > BUF_LEN_B || c_off + {8'h00, len_r} > BIN_SIZE_W))
        c_err = ERR_PARAM;
    end else begin
      if (p2_r[7:3] == 5'h00 ? !cfg_cur_rec_r : p2_r[7:3] != cfg_sfi_rec_r) c_err = ERR_PARAM;
      else if (!c_acc_ok) c_err = ERR_ACCESS;
      else if (op_r == OP_SEARCH) begin
        if (len_r == 8'h00 || len_r > REC_LEN_B || srch_kind_r == 2'h3
            || (srch_kind_r == SK_OFFSET && srch_val_r >= REC_LEN_B)) c_err = ERR_PARAM;
      end else if (len_r != REC_LEN_B) c_err = ERR_PARAM;
      else if (op_r == OP_UPD_REC && cfg_cyc_r) begin
        if (c_mode != MODE_PREV) c_err = ERR_PARAM;
        c_nhead = head_r - 3'h1;
        c_nptr = 4'h1;
        c_tgt = 4'h1;
      end else begin
        // mode decode; P1 unused in next/previous
        unique case (c_mode)
          MODE_ABS: begin
            c_tgt = (p1_r == P1_CURRENT) ? ptr_r : p1_r[3:0];
            if (p1_r > {4'h0, REC_NUM_L} || c_tgt == 4'h0) c_err = ERR_NOREC;
          end
          MODE_NEXT: begin
            if (ptr_r == 4'h0) c_tgt = 4'h1;
            else if (ptr_r != REC_NUM_L) c_tgt = ptr_r + 4'h1;
            else if (cfg_cyc_r) c_tgt = 4'h1;
            else c_err = ERR_NOREC;
            c_nptr = c_tgt;
          end
          MODE_PREV: begin
            if (ptr_r == 4'h0) c_tgt = REC_NUM_L;
            else if (ptr_r != 4'h1) c_tgt = ptr_r - 4'h1;
            else if (cfg_cyc_r) c_tgt = REC_NUM_L;
            else c_err = ERR_NOREC;
            c_nptr = c_tgt;
          end
          default: c_err = ERR_PARAM;
        endcase
      end
    end
  end

  // Search stepping decisions
  logic [7:0] sbyte;
  logic [4:0] sidx, plen;
  logic s_hit, s_adv;
  assign plen = len_r[4:0];
  assign sidx = sfind_r ? spos_r : spos_r + sk_r;
  assign sbyte = rec_mem[{phys_of(srec_r, cfg_cyc_r, head_r), sidx[3:0]}];
  always_comb begin
    s_hit = 1'b0;
    s_adv = 1'b0;
    if (!sfind_r) begin
      if ({1'b0, spos_r} + {1'b0, plen} > 6'h10) s_adv = 1'b1;
      else if (sbyte == buf_r[sk_r] && sk_r == plen - 5'h01) begin
        s_hit = 1'b1;
        s_adv = 1'b1;
      end
    end else if (sbyte != srch_val_r && spos_r == 5'h0F) begin
      s_adv = 1'b1;
    end
  end

  logic emit_wr;
  assign emit_wr = (st_r == S_EMIT) && match_r[erec_r[2:0] - 3'h1]
                   && resp_cnt_r < srch_le_r && resp_cnt_r < BUF_LEN_B;

  // Command sequencer and record pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      {op_r, p1_r, p2_r, len_r} <= 27'h0000000;
      ptr_r <= 4'h0;
      head_r <= 3'h0;
      nptr_r <= 4'h0;
      nhead_r <= 3'h0;
      err_r <= ERR_NONE;
      done_r <= 1'b0;
      to_buf_r <= 1'b1;
      is_rec_r <= 1'b0;
      base_r <= 8'h00;
      cnt_r <= 8'h00;
      resp_cnt_r <= 8'h00;
      {srec_r, first_r, erec_r} <= 12'h000;
      {spos_r, sk_r, start0_r} <= 15'h0000;
      sfind_r <= 1'b0;
      match_r <= 8'h00;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          // A new selection forgets the record pointer
          if (wr && paddr == ADDR_FILECFG) ptr_r <= 4'h0;
          if (wr && paddr == ADDR_CMD) begin
            op_r <= pwdata[2:0];
            p1_r <= pwdata[CMD_P1_LSB +: 8];
            p2_r <= pwdata[CMD_P2_LSB +: 8];
            len_r <= pwdata[CMD_LEN_LSB +: 8];
            done_r <= 1'b0;
            st_r <= S_CHECK;
          end
        end
        S_CHECK: begin
          err_r <= c_err;
          to_buf_r <= c_to_buf;
          is_rec_r <= c_rec;
          nptr_r <= c_nptr;
          nhead_r <= c_nhead;
          cnt_r <= 8'h00;
          base_r <= c_rec ? {1'b0, (c_tgt == 4'h1 && op_r == OP_UPD_REC && cfg_cyc_r)
                                   ? c_nhead : phys_of(c_tgt, cfg_cyc_r, head_r), 4'h0}
                          : c_off[7:0];
          resp_cnt_r <= (c_err == ERR_NONE && c_to_buf && op_r != OP_SEARCH) ? len_r : 8'h00;
          srec_r <= 4'h1;
          first_r <= 4'h0;
          match_r <= 8'h00;
          sk_r <= 5'h00;
          start0_r <= (srch_kind_r == SK_OFFSET) ? srch_val_r[4:0] : 5'h00;
          spos_r <= (srch_kind_r == SK_OFFSET) ? srch_val_r[4:0] : 5'h00;
          sfind_r <= (srch_kind_r == SK_AFTER);
          if (c_err != ERR_NONE) st_r <= S_FIN;
          else if (op_r == OP_SEARCH) st_r <= S_SRCH;
          else if (len_r == 8'h00) st_r <= S_FIN;
          else st_r <= S_MOVE;
        end
        S_MOVE: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == len_r - 8'h01) st_r <= S_FIN;
        end
        S_SRCH: begin
          if (s_hit) begin
            match_r[srec_r[2:0] - 3'h1] <= 1'b1;
            if (first_r == 4'h0) first_r <= srec_r;
          end
          if (s_adv) begin
            if (srec_r == REC_NUM_L) begin
              st_r <= S_EMIT;
              erec_r <= 4'h1;
            end
            srec_r <= srec_r + 4'h1;
            spos_r <= start0_r;
            sk_r <= 5'h00;
            sfind_r <= (srch_kind_r == SK_AFTER);
          end else if (sfind_r) begin
            if (sbyte == srch_val_r) sfind_r <= 1'b0;
            spos_r <= spos_r + 5'h01;
          end else if (sbyte == buf_r[sk_r]) begin
            sk_r <= sk_r + 5'h01;
          end else begin
            sk_r <= 5'h00;
            spos_r <= spos_r + 5'h01;
          end
        end
        S_EMIT: begin
          // up to Le numbers, pointer to first
          if (emit_wr) resp_cnt_r <= resp_cnt_r + 8'h01;
          erec_r <= erec_r + 4'h1;
          if (erec_r == REC_NUM_L) begin
            nptr_r <= (first_r != 4'h0) ? first_r : ptr_r;
            st_r <= S_FIN;
          end
        end
        S_FIN: begin
          if (err_r == ERR_NONE) begin
            ptr_r <= nptr_r;
            head_r <= nhead_r;
          end
          done_r <= 1'b1;
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // File storage and transfer buffer
  logic [7:0] mem_addr;
  assign mem_addr = base_r + cnt_r;
  always_ff @(posedge pclk) begin
    if (st_r == S_MOVE) begin
      if (to_buf_r) begin
        // bytes out of the chosen file
        buf_r[cnt_r[4:0]] <= is_rec_r ? rec_mem[mem_addr[6:0]] : bin_mem[mem_addr];
      end else if (is_rec_r) begin
        rec_mem[mem_addr[6:0]] <= buf_r[cnt_r[4:0]];
      end else begin
        bin_mem[mem_addr] <= buf_r[cnt_r[4:0]];
      end
    end else if (emit_wr) begin
      buf_r[resp_cnt_r[4:0]] <= {4'h0, erec_r};
    end else if (wr && paddr == ADDR_DATA) begin
      buf_r[bufptr_r] <= pwdata[7:0];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // Checks
  sequence s_rec_done;
    ##17 (st_r == S_FIN) ##1 (st_r == S_IDLE);
  endsequence

  chk_fail_keeps_ptr: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == S_FIN && err_r != ERR_NONE) |=> $stable(ptr_r))
    else $error("pointer moved by a failed command");
  chk_abs_no_move: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == S_CHECK && op_r == OP_RD_REC && c_mode == MODE_ABS && c_err == ERR_NONE)
    |-> s_rec_done ##0 (ptr_r == $past(ptr_r, 18)))
    else $error("absolute read moved the pointer");
  chk_next_unset: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == S_CHECK && op_r == OP_RD_REC && c_mode == MODE_NEXT && ptr_r == 4'h0
     && c_err == ERR_NONE) |-> s_rec_done ##0 (ptr_r == 4'h1))
    else $error("next read from unset pointer did not land on first record");
  chk_lin_next_end: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == S_CHECK && op_r == OP_RD_REC && c_mode == MODE_NEXT && !cfg_cyc_r
     && ptr_r == REC_NUM_L && c_err != ERR_PARAM && c_err != ERR_ACCESS)
    |=> (st_r == S_FIN && err_r == ERR_NOREC) ##1 (ptr_r == REC_NUM_L))
    else $error("linear next read past last record not refused");
  chk_cyc_prev_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == S_CHECK && op_r == OP_RD_REC && c_mode == MODE_PREV && cfg_cyc_r
     && ptr_r == 4'h1 && c_err == ERR_NONE) |-> s_rec_done ##0 (ptr_r == REC_NUM_L))
    else $error("cyclic previous read did not wrap to last record");
  chk_cyc_upd_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == S_CHECK && op_r == OP_UPD_REC && cfg_cyc_r && c_mode != MODE_PREV
     && cfg_upd_ok_r && len_r == REC_LEN_B && p2_r[7:3] == 5'h00 && cfg_cur_rec_r)
    |=> (err_r == ERR_PARAM) && (st_r == S_FIN))
    else $error("cyclic update in a forbidden mode was accepted");
  chk_cyc_renumber: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == S_CHECK && op_r == OP_UPD_REC && cfg_cyc_r && c_err == ERR_NONE)
    |-> s_rec_done ##0 (ptr_r == 4'h1 && head_r == $past(head_r, 18) - 3'h1))
    else $error("cyclic update did not renumber oldest record as first");
  chk_read_access: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == S_CHECK && op_r == OP_RD_BIN && !cfg_rd_ok_r && !p1_r[7] && !cfg_cur_rec_r)
    |=> (err_r == ERR_ACCESS) ##1 (st_r == S_IDLE && done_r && resp_cnt_r == 8'h00))
    else $error("binary read without read access not refused");

endmodule : card_file_cmd

/* File: rtl/card_file_pkg.sv */
// Constants for the card file access command engine.
// Assumes an APB3 master with 8-bit byte addresses and 32-bit data.
package card_file_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FILECFG = 8'h08;
  localparam logic [7:0] ADDR_BUFPTR = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam logic [7:0] ADDR_SEARCH = 8'h14;
  // Command opcodes in CMD[2:0]
  localparam logic [2:0] OP_RD_BIN = 3'h1;
  localparam logic [2:0] OP_UPD_BIN = 3'h2;
  localparam logic [2:0] OP_RD_REC = 3'h3;
  localparam logic [2:0] OP_UPD_REC = 3'h4;
  localparam logic [2:0] OP_SEARCH = 3'h5;
  // CMD field positions
  localparam int CMD_P1_LSB = 8;
  localparam int CMD_P2_LSB = 16;
  localparam int CMD_LEN_LSB = 24;
  // FILECFG field positions
  localparam int CFG_CUR_REC = 0;
  localparam int CFG_CYCLIC = 1;
  localparam int CFG_RD_OK = 2;
  localparam int CFG_UPD_OK = 3;
  localparam int CFG_SFIB_LSB = 4;
  localparam int CFG_SFIR_LSB = 9;
  localparam logic [13:0] CFG_RESET = 14'h0000;
  // STATUS field positions
  localparam int STS_BUSY = 0;
  localparam int STS_DONE = 1;
  localparam int STS_ERR_LSB = 2;
  localparam int STS_CNT_LSB = 8;
  localparam int STS_PTR_LSB = 16;
  localparam int STS_HEAD_LSB = 20;
  // SEARCH field positions
  localparam int SRCH_LE_LSB = 0;
  localparam int SRCH_KIND_LSB = 8;
  localparam int SRCH_VAL_LSB = 16;
  localparam logic [1:0] SK_SIMPLE = 2'h0;
  localparam logic [1:0] SK_OFFSET = 2'h1;
  localparam logic [1:0] SK_AFTER = 2'h2;
  // Parameter byte codings
  localparam logic [2:0] P1_SFI_TAG = 3'h4;
  localparam logic [2:0] MODE_NEXT = 3'h2;
  localparam logic [2:0] MODE_PREV = 3'h3;
  localparam logic [2:0] MODE_ABS = 3'h4;
  localparam logic [7:0] P1_CURRENT = 8'h00;
  // Error codes
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_ACCESS = 2'h1;
  localparam logic [1:0] ERR_PARAM = 2'h2;
  localparam logic [1:0] ERR_NOREC = 2'h3;
  // File geometry
  localparam int BIN_SIZE = 256;
  localparam logic [15:0] BIN_SIZE_W = 16'h0100;
  localparam int REC_NUM = 8;
  localparam logic [3:0] REC_NUM_L = 4'h8;
  localparam int REC_LEN = 16;
  localparam logic [7:0] REC_LEN_B = 8'h10;
  localparam int BUF_LEN = 32;
  localparam logic [7:0] BUF_LEN_B = 8'h20;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CHECK = 3'b001,
    S_MOVE = 3'b011,
    S_FIN = 3'b111,
    S_SRCH = 3'b010,
    S_EMIT = 3'b110
  } state_t;
endpackage : card_file_pkg

/* File: dv/card_terminal.sv */
// Terminal model: APB master that carries command headers and buffer bytes.
// Assumes the bench calls xfer right after a rising pclk edge.
`timescale 1ns/1ps
module card_terminal (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse so stale values never pass
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask : xfer
endmodule : card_terminal

/* File: dv/test_card_file_access_commands.sv */
// Self-checking bench for the card file command engine.
// Assumes card_terminal is the only APB master and the design the only slave.
`timescale 1ns/1ps
module test_card_file_access_commands;
  import card_file_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int errors = 0;
  int compares = 0;
  integer seed = 58;
  // Byte model: transparent file at 0..255, records and fresh data from 256
  logic [7:0] mm [0:415];
  int offs [3];
  int lens [3];
  // cfg, op, p1, p2, pointer, err, data base
  int steps [0:22][0:6] = '{
    '{'h60D,3,0,2,1,0,256}, '{0,3,0,2,2,0,272}, '{0,3,0,3,1,0,256}, '{0,3,0,3,1,3,-1},
    '{0,3,0,4,1,0,256}, '{0,3,5,'h1C,1,0,320}, '{'h60D,3,0,3,8,0,368}, '{0,3,0,2,8,3,-1},
    '{0,3,0,'h22,8,2,-1}, '{0,3,0,1,8,2,-1}, '{'h609,3,0,2,0,1,-1}, '{'h605,4,2,4,0,1,-1},
    '{'h60D,4,'h77,2,1,0,384}, '{0,3,1,4,1,0,384}, '{0,4,0,3,1,3,-1},
    '{'h60F,3,0,3,8,0,368}, '{0,3,0,2,1,0,384}, '{0,3,0,3,8,0,368}, '{0,4,1,4,8,2,-1},
    '{0,4,0,2,8,2,-1}, '{0,4,0,3,1,0,400}, '{0,3,0,4,1,0,400}, '{0,3,2,4,1,0,384}};

  always #2.5 pclk = ~pclk;

  card_file_cmd u_card_file_cmd (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  card_terminal u_card_terminal (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] sts(input logic [1:0] err, input logic [3:0] ptr);
    return {12'h000, ptr, 12'h000, err, 2'b10};
  endfunction : sts

  task automatic chk_sts(input logic [31:0] s, input logic [1:0] err, input logic [3:0] ptr);
    chk(s & 32'h000F_000E, sts(err, ptr));
  endtask : chk_sts

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    u_card_terminal.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    u_card_terminal.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic putbuf(input int n, input int base);
    wr(ADDR_BUFPTR, 32'h0000_0000);
    for (int i = 0; i < n; i++) wr(ADDR_DATA, {24'h000000, mm[base+i]});
  endtask : putbuf

  task automatic getbuf(input int n, input int base);
    logic [31:0] q;
    logic e;
    wr(ADDR_BUFPTR, 32'h0000_0000);
    for (int i = 0; i < n; i++) begin
      rd(ADDR_DATA, q, e);
      chk(q, {24'h000000, mm[base+i]});
    end
  endtask : getbuf

  // header carries the count, data goes through the buffer
  task automatic cmd(input logic [2:0] op, input logic [7:0] p1, input logic [7:0] p2,
                     input logic [7:0] n, output logic [31:0] s);
    logic e;
    wr(ADDR_CMD, {n, p2, p1, 5'h00, op});
    do rd(ADDR_STATUS, s, e); while (s[STS_BUSY] !== 1'b0);
  endtask : cmd

  task automatic wrap_up;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    errors++;
    wrap_up();
  end

  initial begin
    logic [31:0] q, s;
    logic e;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_STATUS, q, e);
    chk(q, 32'h0000_0000);
    rd(ADDR_FILECFG, q, e);
    chk(q, {18'h00000, CFG_RESET});
    rd(8'h18, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    for (int i = 256; i < 416; i++) mm[i] = 8'($random(seed));
    wr(ADDR_FILECFG, 32'h0000_005C);
    for (int k = 0; k < 3; k++) begin
      offs[k] = $random(seed) & 32'hDF;
      lens[k] = ($random(seed) & 32'h1F) + 1;
      for (int i = 0; i < lens[k]; i++) mm[offs[k]+i] = 8'($random(seed));
      putbuf(lens[k], offs[k]);
      cmd(OP_UPD_BIN, 8'h00, 8'(offs[k]), 8'(lens[k]), s);
      chk_sts(s, ERR_NONE, 4'h0);
    end
    cmd(OP_RD_BIN, 8'h01, 8'h00, 8'h01, s);
    chk_sts(s, ERR_PARAM, 4'h0);
    cmd(OP_RD_BIN, {P1_SFI_TAG, 5'h06}, 8'h00, 8'h01, s);
    chk_sts(s, ERR_PARAM, 4'h0);
    wr(ADDR_FILECFG, 32'h0000_0050);
    cmd(OP_UPD_BIN, 8'h00, 8'(offs[0]), 8'(lens[2]), s);
    chk_sts(s, ERR_ACCESS, 4'h0);
    cmd(OP_RD_BIN, 8'h00, 8'h00, 8'h01, s);
    chk_sts(s, ERR_ACCESS, 4'h0);
    wr(ADDR_FILECFG, 32'h0000_005C);
    for (int k = 0; k < 3; k++) begin
      cmd(OP_RD_BIN, {P1_SFI_TAG, 5'h05}, 8'(offs[k]), 8'(lens[k]), s);
      chk_sts(s, ERR_NONE, 4'h0);
      getbuf(lens[k], offs[k]);
    end
    wr(ADDR_FILECFG, 32'h0000_060D);
    for (int r = 1; r <= 8; r++) begin
      putbuf(16, 240 + 16 * r);
      cmd(OP_UPD_REC, 8'(r), {5'h00, MODE_ABS}, REC_LEN_B, s);
      chk_sts(s, ERR_NONE, 4'h0);
    end
    for (int i = 0; i < 23; i++) begin
      if (steps[i][0] != 0) wr(ADDR_FILECFG, 32'(steps[i][0]));
      if (steps[i][1] == 4 && steps[i][6] >= 0) putbuf(16, steps[i][6]);
      cmd(3'(steps[i][1]), 8'(steps[i][2]), 8'(steps[i][3]), REC_LEN_B, s);
      chk_sts(s, 2'(steps[i][5]), 4'(steps[i][4]));
      if (steps[i][1] == 3 && steps[i][6] >= 0) getbuf(16, steps[i][6]);
    end
    cmd(OP_RD_REC, P1_CURRENT, {5'h00, MODE_PREV}, REC_LEN_B, s);
    chk(s, 32'h0078_1002);
    getbuf(16, 352);
    wr(ADDR_SEARCH, {16'h0000, 6'h00, SK_SIMPLE, 8'h08});
    putbuf(16, 400);
    cmd(OP_SEARCH, 8'h00, 8'h00, REC_LEN_B, s);
    chk_sts(s, ERR_NONE, 4'h1);
    chk({24'h000000, s[15:8]}, 32'h0000_0001);
    wr(ADDR_BUFPTR, 32'h0000_0000);
    rd(ADDR_DATA, q, e);
    chk(q, 32'h0000_0001);
    cmd(OP_RD_REC, P1_CURRENT, {5'h00, MODE_NEXT}, REC_LEN_B, s);
    chk_sts(s, ERR_NONE, 4'h2);
    // Offset search with an empty Le still moves the pointer
    wr(ADDR_SEARCH, {16'h0004, 6'h00, SK_OFFSET, 8'h00});
    putbuf(12, 404);
    cmd(OP_SEARCH, 8'h00, 8'h00, 8'h0C, s);
    chk_sts(s, ERR_NONE, 4'h1);
    chk({24'h000000, s[15:8]}, 32'h0000_0000);
    wr(ADDR_SEARCH, {8'h00, mm[400], 6'h00, SK_AFTER, 8'h08});
    putbuf(15, 401);
    cmd(OP_SEARCH, 8'h00, 8'h00, 8'h0F, s);
    chk({24'h000000, s[15:8]}, 32'h0000_0001);
    wr(ADDR_BUFPTR, 32'h0000_0000);
    rd(ADDR_DATA, q, e);
    chk(q, 32'h0000_0001);
    // Reset in mid-run forgets pointer, head and done
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_STATUS, q, e);
    chk(q, 32'h0000_0000);
    wrap_up();
  end
endmodule : test_card_file_access_commands
